// *** common/charge_pkg.sv ***
// Functional notes
// - Power-up, replacement, wake, depletion start cycles.
// - Every new cycle begins in qualification.
// - Low cell voltage sends qualification to pending.
// - Pending pulses gate once per second.
// - Pending blinks active-low lamp at 1 Hz.
// - Temperature outside window holds off fast charge.
// - Over-temperature also stops pending trickle pulses.
// - Fast charge needs voltage and temperature valid.
// - Reaching max cell level marks lithium pack.
// - Nickel fast charge current-limited, time/temp/rate terminated.
// - Top-off only when selected, else maintenance.
// - Nickel maintenance trickles while below max level.
// - Lithium constant current until max level reached.
// - Lithium constant voltage ends at minimum current.
// - Finished lithium restarts below recharge threshold.
// - Lithium stages check time, temperature, current/voltage.
// - No maintenance trickle after lithium termination.
// - Gate high passes current, low blocks it.
// - Charge time, hold-off, width, top-off from program.
// - Lithium constant-voltage entry restarts charge timer.
// - Temperature sampled every 16 s, compared two back.
// - Rate termination disabled for max time / 32.
// - Top-off lasts max time at one sixteenth rate.
package charge_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned TICK_NS        = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  TICKS_PER_SEC  = 10'h3e8;
  localparam logic [9:0]  HALF_SEC_TICK  = 10'h1f3;
  localparam logic [3:0]  RATE_SAMPLE_S  = 4'hf;
  localparam int unsigned HOLDOFF_SHIFT  = 5;
  localparam logic [7:0]  RATE_DROP_MIN  = 8'h04;
  localparam logic [3:0]  TOPOFF_DUTY    = 4'hf;

  localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET  = 4'h4;
  localparam logic [3:0]  TIMER_OFFSET   = 4'h8;
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam logic        CTRL_SLEEP_RST = 1'b0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_QUAL, ST_PEND, ST_FAST, ST_TOPOFF, ST_MAINT, ST_LI_CV, ST_LI_DONE
  } charge_state_t;

  // Digitised comparator results, all from the analog front end
  typedef struct packed {
    logic       present;
    logic       below_low_cell;
    logic       at_max_cell;
    logic       below_recharge;
    logic       cold_fault;
    logic       hot_fault;
    logic       hot_cutoff;
    logic       current_high;
    logic       current_below_min;
    logic [7:0] temp_code;
  } sense_t;

  typedef struct packed {
    logic [15:0] max_charge_time_s;
    logic [9:0]  trickle_width_ms;
    logic        topoff_en;
  } timing_program_t;
endpackage : charge_pkg

// *** hdl/sense_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sense_sync
  import charge_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire sense_t async_i,
  output sense_t      sync_o
);
  sense_t stage1_q;

  // First stage is read only by the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1_q <= '0;
      sync_o   <= '0;
    end else begin
      stage1_q <= async_i;
      sync_o   <= stage1_q;
    end
  end
endmodule : sense_sync
`default_nettype wire

// *** hdl/charge_sequencer.sv ***
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module charge_sequencer
  import charge_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire sense_t          sense_in_i,
  input  wire timing_program_t timing_program_in_i,
  output logic                 charge_gate_out_o,
  output logic                 status_lamp_n_o,
  output logic                 status_lamp_oe_o,
  input  wire logic [3:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [3:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  sense_t          sn;
  timing_program_t cfg_q, prog_meta_q, prog_sync_q;
  charge_state_t   state_q, state_d;
  logic [16:0]     div_q;
  logic            tick_q;
  logic [9:0]      ms_q;
  logic            sec_tick, half_tick;
  logic [3:0]      rate_cnt_q;
  logic [15:0]     phase_sec_q;
  logic [7:0]      temp_old_q, temp_mid_q;
  logic            rate_trip_q;
  logic            chem_li_q;
  logic            sleep_q, start_req_q;
  logic            temp_ok, timed_out, gate_d, lamp_on_d;
  logic [3:0]      aw_addr_q;
  logic [31:0]     wdata_q;
  logic            wstrb0_q;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised comparator inputs
  sense_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (sense_in_i),
    .sync_o  (sn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick from clock count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == 17'(TICK_LEN - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 17'h1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_q <= '0;
    // Restart on phase entry, else a phase may end up to 1 s early
    end else if (state_d != state_q) begin
      ms_q <= '0;
    end else if (tick_q) begin
      ms_q <= (ms_q == TICKS_PER_SEC - 10'h1) ? 10'h0 : ms_q + 10'h1;
    end
  end

  assign sec_tick  = tick_q && (ms_q == TICKS_PER_SEC - 10'h1);
  assign half_tick = tick_q && (ms_q == HALF_SEC_TICK || ms_q == TICKS_PER_SEC - 10'h1);

  ////////////////////////////////////////////////////////////////////////////
  // program latched at cycle start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_meta_q <= '0;
      prog_sync_q <= '0;
      cfg_q       <= '0;
    end else begin
      // Program pins pass two flops before use
      prog_meta_q <= timing_program_in_i;
      prog_sync_q <= prog_meta_q;
      if (state_d == ST_QUAL && state_q != ST_QUAL) begin
        cfg_q <= prog_sync_q;
      end
    end
  end

  // Seconds in the current phase; cleared on every state change
  // timer restarts on entry to constant voltage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_sec_q <= '0;
    end else if (state_d != state_q) begin
      phase_sec_q <= '0;
    end else if (sec_tick && phase_sec_q != 16'hffff) begin
      phase_sec_q <= phase_sec_q + 16'h1;
    end
  end

  assign timed_out = (phase_sec_q >= cfg_q.max_charge_time_s);
  assign temp_ok   = !sn.cold_fault && !sn.hot_fault;

  ////////////////////////////////////////////////////////////////////////////
  // sample every 16 s, compare two back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_cnt_q  <= '0;
      temp_mid_q  <= '0;
      temp_old_q  <= '0;
      rate_trip_q <= 1'b0;
    end else if (state_q != ST_FAST) begin
      rate_cnt_q  <= '0;
      temp_mid_q  <= sn.temp_code;
      temp_old_q  <= sn.temp_code;
      rate_trip_q <= 1'b0;
    end else if (sec_tick) begin
      rate_cnt_q <= rate_cnt_q + 4'h1;
      if (rate_cnt_q == RATE_SAMPLE_S) begin
        temp_old_q <= temp_mid_q;
        temp_mid_q <= sn.temp_code;
        // hold-off is max time over 32
        if (phase_sec_q >= (cfg_q.max_charge_time_s >> HOLDOFF_SHIFT)
            && temp_old_q > sn.temp_code
            && (temp_old_q - sn.temp_code) >= RATE_DROP_MIN) begin
          rate_trip_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        // insertion or wake starts a cycle
        if (sn.present && !sleep_q) begin
          state_d = ST_QUAL;
        end
      end
      ST_QUAL: begin
        if (sn.below_low_cell) begin
          state_d = ST_PEND;
        end else if (temp_ok) begin
          state_d = ST_FAST;
        end
      end
      ST_PEND: begin
        if (!sn.below_low_cell && temp_ok) begin
          state_d = ST_FAST;
        end
      end
      ST_FAST: begin
        // constant current ends at max level
        if (sn.at_max_cell) begin
          state_d = ST_LI_CV;
        end else if (timed_out || sn.hot_cutoff || rate_trip_q) begin
          state_d = cfg_q.topoff_en ? ST_TOPOFF : ST_MAINT;
        end
      end
      ST_TOPOFF: begin
        // top-off lasts one max charge time
        if (timed_out) begin
          state_d = ST_MAINT;
        end
      end
      ST_MAINT: begin
        state_d = ST_MAINT;
      end
      ST_LI_CV: begin
        if (sn.current_below_min || timed_out || sn.hot_cutoff) begin
          state_d = ST_LI_DONE;
        end
      end
      ST_LI_DONE: begin
        if (sn.below_recharge) begin
          state_d = ST_QUAL;
        end
      end
    endcase
    // Removal or sleep overrides everything; a restart request wins next
    if (!sn.present || sleep_q) begin
      state_d = ST_IDLE;
    end else if (start_req_q) begin
      state_d = ST_QUAL;
    end
  end

  // reset release is the power-up start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_QUAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chem_li_q <= 1'b0;
    end else if (state_d == ST_QUAL) begin
      chem_li_q <= 1'b0;
    end else if (state_q == ST_FAST && state_d == ST_LI_CV) begin
      chem_li_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate and lamp
  always_comb begin
    gate_d    = 1'b0;
    lamp_on_d = 1'b0;
    unique case (state_q)
      ST_PEND: begin
        // one pulse of programmed width per second
        gate_d    = (ms_q < cfg_q.trickle_width_ms) && !sn.hot_fault;
        // toggled lamp gives 1 Hz blink
        lamp_on_d = status_lamp_oe_o ^ half_tick;
      end
      ST_FAST: begin
        gate_d    = temp_ok && !sn.current_high;
        lamp_on_d = 1'b1;
      end
      ST_TOPOFF: begin
        gate_d    = (ms_q[3:0] == TOPOFF_DUTY) && !sn.current_high
                    && !sn.at_max_cell && !sn.hot_fault;
        lamp_on_d = 1'b0;
      end
      ST_MAINT: begin
        gate_d    = (ms_q < cfg_q.trickle_width_ms) && !sn.at_max_cell && !sn.hot_fault;
      end
      ST_LI_CV: begin
        gate_d    = temp_ok && !sn.at_max_cell && !sn.current_high;
        lamp_on_d = 1'b1;
      end
      ST_IDLE, ST_QUAL, ST_LI_DONE: begin
        gate_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      charge_gate_out_o <= 1'b0;
      status_lamp_oe_o  <= 1'b0;
      status_lamp_n_o   <= 1'b0;
    end else begin
      charge_gate_out_o <= gate_d;
      status_lamp_oe_o  <= lamp_on_d;
      status_lamp_n_o   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, read data one cycle after handshake, write response two
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_q     <= '0;
      wdata_q       <= '0;
      wstrb0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == CTRL_OFFSET) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Sleep level and one-shot restart from the control word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_q     <= CTRL_SLEEP_RST;
      start_req_q <= 1'b0;
    end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid
                 && aw_addr_q == CTRL_OFFSET && wstrb0_q) begin
      sleep_q     <= wdata_q[CTRL_SLEEP_BIT];
      start_req_q <= wdata_q[CTRL_START_BIT];
    end else begin
      start_req_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFFSET:   s_axi_rdata <= {31'h0, sleep_q};
        STATUS_OFFSET: s_axi_rdata <= {24'h0, rate_trip_q, status_lamp_oe_o,
                                       charge_gate_out_o, chem_li_q, state_q};
        TIMER_OFFSET:  s_axi_rdata <= {16'h0, phase_sec_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_qual_to_pend: assert property (
    state_q == ST_QUAL && sn.present && !sleep_q && !start_req_q && sn.below_low_cell
    |=> state_q == ST_PEND) else $error("qualification missed pending");
  a_fast_needs_ok: assert property (
    state_q != ST_FAST ##1 state_q == ST_FAST |-> $past(temp_ok && !sn.below_low_cell))
    else $error("fast charge without valid conditions");
  a_hot_no_trickle: assert property (
    state_q == ST_PEND && sn.hot_fault |=> !charge_gate_out_o)
    else $error("trickle while hot");
  a_cold_hold_off: assert property (
    state_q == ST_FAST && !temp_ok |=> !charge_gate_out_o)
    else $error("fast gate outside temperature window");
  a_li_detect: assert property (
    state_q == ST_FAST && sn.at_max_cell && sn.present && !sleep_q && !start_req_q
    |=> state_q == ST_LI_CV && chem_li_q) else $error("lithium not detected");
  a_cv_timer_zero: assert property (
    state_q == ST_FAST ##1 state_q == ST_LI_CV |-> phase_sec_q == 16'h0)
    else $error("timer not restarted in constant voltage");
  a_li_no_maint: assert property (
    state_q == ST_LI_DONE |=> !charge_gate_out_o && state_q != ST_MAINT)
    else $error("maintenance after lithium");
  a_holdoff_rate: assert property (
    $rose(rate_trip_q) |-> phase_sec_q >= (cfg_q.max_charge_time_s >> HOLDOFF_SHIFT))
    else $error("rate trip inside hold-off");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");

  c_pending: cover property (state_q == ST_PEND ##1 state_q == ST_FAST);
  c_topoff:  cover property (state_q == ST_TOPOFF ##1 state_q == ST_MAINT);
  c_li_done: cover property (state_q == ST_LI_CV ##1 state_q == ST_LI_DONE);
  c_recharge: cover property (state_q == ST_LI_DONE ##1 state_q == ST_QUAL);
endmodule : charge_sequencer
`default_nettype wire

// *** verification/sense_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sense_model
  import charge_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   gate_i,
  input  wire sense_t env_i,
  output sense_t      sense_o
);
  logic [1:0] coil_q;

  // Inductor lags the gate, so current trails it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      coil_q <= 2'h0;
    end else begin
      coil_q <= {coil_q[0], gate_i};
    end
  end

  always_comb begin
    sense_o              = env_i;
    sense_o.current_high = coil_q[1];
  end
endmodule : sense_model
`default_nettype wire

// *** verification/battery_charge_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_tb
  import charge_pkg::*;
;
  localparam int TL    = 4;
  localparam int SEC   = 1000 * TL;
  localparam int LIMIT = 100000;
  logic            clk_i;
  logic            rst_i;
  sense_t          env;
  sense_t          current_sense_in;
  timing_program_t prog;
  logic            gate;
  logic            lamp_n;
  logic            lamp_oe;
  logic            lamp_w;
  logic [3:0]      awaddr;
  logic [3:0]      wstrb;
  logic [3:0]      araddr;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  logic [31:0]     wdata, rdata, st, g, t;
  logic [1:0]      bresp, rresp, resp;
  int              error_cnt, checks, cyc;

  // Open-drain lamp line idles high through a pull-up
  assign lamp_w = lamp_oe ? lamp_n : 1'b1;

  sense_model sense_model_i (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gate), .env_i(env),
    .sense_o(current_sense_in));

  charge_sequencer #(.TICK_LEN(TL)) charge_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .sense_in_i(current_sense_in), .timing_program_in_i(prog),
    .charge_gate_out_o(gate), .status_lamp_n_o(lamp_n), .status_lamp_oe_o(lamp_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready and answers are looked at mid-cycle, where registered outputs are settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clk_i);
      if (awvalid && awready) aw = 1'b1;
      if (wvalid && wready) w = 1'b1;
      @(posedge clk_i);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    do @(negedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk_i);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clk_i); while (arready !== 1'b1);
    @(posedge clk_i);
    arvalid <= 1'b0;
    do @(negedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk_i);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_st(input logic [3:0] e);
    int n;
    n = 0;
    do begin
      axi_rd(STATUS_OFFSET, st, resp);
      n++;
    end while (st[3:0] !== e && n < 3000);
    chk({28'h0, st[3:0]}, {28'h0, e});
  endtask : wait_st

  // Gate-high cycles and lamp edges over n cycles
  task automatic meas(input int n);
    logic prev;
    g    = 32'h0;
    t    = 32'h0;
    // Let gate and lamp settle past the input synchronisers
    repeat (4) @(negedge clk_i);
    prev = lamp_w;
    repeat (n) begin
      @(negedge clk_i);
      g = g + {31'h0, gate};
      if (lamp_w !== prev) t = t + 32'h1;
      prev = lamp_w;
    end
  endtask : meas

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    checks    = 0;
    cyc       = 0;
    rst_i     = 1'b1;
    env       = '0;
    env.present        = 1'b1;
    env.below_low_cell = 1'b1;
    env.temp_code      = 8'h80;
    prog.max_charge_time_s = 16'h0001;
    prog.trickle_width_ms  = 10'h003;
    prog.topoff_en         = 1'b1;
    {awaddr, wstrb, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    axi_rd(CTRL_OFFSET, st, resp);
    chk(st, 32'h0); // sleep off after reset
    axi_rd(4'hc, st, resp);
    chk({30'h0, resp}, {30'h0, RESP_DECERR});
    axi_wr(STATUS_OFFSET, 32'hff, resp);
    chk({30'h0, resp}, {30'h0, RESP_DECERR});
    wait_st(ST_PEND); // low cell pends
    meas(SEC);
    chk(g, 3 * TL); // trickle width
    chk(t, 32'h2); // lamp blink
    @(posedge clk_i) env.hot_fault <= 1'b1;
    meas(SEC);
    chk(g, 32'h0); // no hot trickle
    @(posedge clk_i) {env.hot_fault, env.cold_fault, env.below_low_cell} <= 3'b010;
    meas(SEC);
    axi_rd(STATUS_OFFSET, st, resp);
    chk({31'h0, st[3:0] == 4'h3}, 32'h0); // cold hold-off
    @(posedge clk_i) env.cold_fault <= 1'b0;
    wait_st(ST_FAST); // both valid
    meas(64);
    chk({31'h0, g != 32'h0 && g != 32'd64}, 32'h1); // gate regulates
    wait_st(ST_TOPOFF); // time limit
    meas(SEC / 2);
    axi_rd(STATUS_OFFSET, st, resp);
    chk({28'h0, st[3:0]}, {28'h0, ST_TOPOFF}); // top-off length
    wait_st(ST_MAINT); // maintenance follows
    meas(SEC);
    chk(g, 3 * TL); // trickle continues
    @(posedge clk_i) env.at_max_cell <= 1'b1;
    meas(SEC);
    chk(g, 32'h0); // stops at max
    @(posedge clk_i) env.at_max_cell <= 1'b0;
    axi_wr(CTRL_OFFSET, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}); // control write accepted
    wait_st(ST_IDLE); // sleep entry
    axi_wr(CTRL_OFFSET, 32'h0, resp);
    wait_st(ST_FAST); // wake restarts
    // Program flipped after start must be ignored
    @(posedge clk_i) prog.topoff_en <= 1'b0;
    axi_wr(CTRL_OFFSET, 32'h2, resp);
    @(posedge clk_i) prog.topoff_en <= 1'b1;
    wait_st(ST_FAST);
    @(posedge clk_i) env.hot_cutoff <= 1'b1;
    wait_st(ST_MAINT); // skip top-off
    @(posedge clk_i) env.hot_cutoff <= 1'b0;
    axi_wr(CTRL_OFFSET, 32'h2, resp);
    wait_st(ST_FAST);
    @(posedge clk_i) env.at_max_cell <= 1'b1;
    wait_st(ST_LI_CV); // lithium detect
    chk({31'h0, st[4]}, 32'h1); // lithium flag
    axi_rd(TIMER_OFFSET, st, resp);
    chk(st, 32'h0); // timer restarted
    @(posedge clk_i) env.current_below_min <= 1'b1;
    wait_st(ST_LI_DONE); // minimum current
    meas(SEC);
    chk(g, 32'h0); // no maintenance
    @(posedge clk_i) {env.at_max_cell, env.current_below_min} <= 2'b00;
    @(posedge clk_i) env.below_recharge <= 1'b1;
    wait_st(ST_FAST); // recharge restart
    @(posedge clk_i) {env.below_recharge, env.present} <= 2'b00;
    wait_st(ST_IDLE); // removal
    @(posedge clk_i) env.present <= 1'b1;
    wait_st(ST_FAST); // insertion restarts
    summarize();
  end
endmodule : battery_charge_sequencer_tb
`default_nettype wire
